// file: include/pin_change_pkg.sv
// constants and types for the pin change interrupt block
package pin_change_pkg;

  localparam int NPORTS = 3;
  localparam int PORT_W = 8;
  localparam int PINS_W = NPORTS * PORT_W;
  localparam int SYNC_W = PINS_W + 2;

  typedef logic [PORT_W-1:0] port_byte_t;

  // one byte per port, port a in the low byte
  typedef struct packed {
    port_byte_t c;
    port_byte_t b;
    port_byte_t a;
  } port_trio_t;

  // wishbone request as seen by the register file
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  // register indices, byte address is four times the index
  localparam logic [2:0][13:0] RISE_IDX = {14'h1f53, 14'h1f48, 14'h1f3d};
  localparam logic [2:0][13:0] FALL_IDX = {14'h1f54, 14'h1f49, 14'h1f3e};
  localparam logic [2:0][13:0] FLAG_IDX = {14'h1f55, 14'h1f4a, 14'h1f3f};
  localparam logic [13:0] CTRL_IDX      = 14'h1f60;
  localparam logic [13:0] SUMMARY_IDX   = 14'h1f61;
  localparam logic [13:0] EVT_STAT_IDX  = 14'h1f62;
  localparam logic [13:0] EVT_MASK_IDX  = 14'h1f63;

  // field positions
  localparam int MASTER_EN_BIT = 0;
  localparam int SUMMARY_BIT   = 0;
  localparam int RESET_PIN_BIT = 3;
  localparam int FUSE_RST_POS  = PINS_W;
  localparam int FUSE_LVP_POS  = PINS_W + 1;

  // implemented pins per port
  localparam logic [2:0][7:0] PORT_PINS = {8'hff, 8'hf0, 8'h3f};

  // reset values
  localparam port_byte_t REG_RST = 8'h00;
  localparam logic [2:0] EVT_RST = 3'h0;

  // last priming count; detection starts on the cycle after it, four cycles after reset
  localparam logic [1:0] PRIME_CYCLES = 2'h3;

  typedef enum logic [1:0] {
    ST_PRIME = 2'b01,
    ST_RUN   = 2'b10
  } det_state_t;

endpackage : pin_change_pkg

// file: logic/pin_change_interrupt.sv
// pin change interrupt controller with wishbone register access
//
// Function
// - any pin or set of pins can request on a rising or falling edge.
// - port a always, port c from the 14-pin size, port b at 20 pins.
// - with either fuse at one, the reset pin has no detection.
// - master enable clear: edges still set flags, change_irq_o stays low, irq_o is not gated.
// - each pin has a rising detector, live while its rise bit is one.
// - each pin has a falling detector, live while its fall bit is one.
// - with both enables set, a pin detects both directions at once.
// - an enabled edge sets its flag, change_irq_o needs the master enable, irq_o does not.
// - the summary request bit is the or of all pin flags of all ports.
// - the summary bit ignores writes and clears once every flag is zero.
// - software clears a pin flag by writing zero to its bit.
// - an edge during a flag write wins over the written value.
// - with master enable set, an enabled edge in sleep wakes the device.
// - the flags are updated before the first instruction after wake-up.
//
// The implementer's own choices: the address map and the Wishbone register port.
module pin_change_interrupt
  import pin_change_pkg::*;
#(
  parameter int PACKAGE_PINS = 20
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [15:0]              wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire pin_change_pkg::port_trio_t pins_i,
  input  wire logic                     reset_pin_enable_fuse_i,
  input  wire logic                     low_voltage_program_fuse_i,
  input  wire logic                     sleep_i,
  output logic                          change_irq_o,
  output logic                          wake_o,
  output logic                          irq_o
);
  import pin_change_pkg::*;

  // register hit against a word index
  function automatic logic idx_hit(input logic [15:0] adr,
                                   input logic [13:0] idx);
    return adr[15:2] == idx;
  endfunction

  // byte p of a 24-bit pin vector
  function automatic port_byte_t byte_of(input logic [PINS_W-1:0] v,
                                         input int p);
    return v[p*PORT_W +: PORT_W];
  endfunction

  wb_req_t          req;
  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic [SYNC_W-1:0] lvl_r;
  logic [SYNC_W-1:0] lvl_nxt;
  det_state_t       state_r;
  det_state_t       state_nxt;
  logic [1:0]       prime_r;
  logic [1:0]       prime_nxt;
  logic [PINS_W-1:0] rise_r;
  logic [PINS_W-1:0] rise_nxt;
  logic [PINS_W-1:0] fall_r;
  logic [PINS_W-1:0] fall_nxt;
  logic [PINS_W-1:0] flag_r;
  logic [PINS_W-1:0] flag_nxt;
  logic [PINS_W-1:0] avail;
  logic [PINS_W-1:0] rise_ev;
  logic [PINS_W-1:0] fall_ev;
  logic [PINS_W-1:0] edge_ev;
  logic             master_en_r;
  logic [2:0]       evt_stat_r;
  logic [2:0]       evt_stat_nxt;
  logic [2:0]       evt_mask_r;
  logic [2:0]       port_ev;
  logic             ack_r;
  logic [31:0]      rdat_r;
  logic [31:0]      rdat_nxt;
  logic [2:0]       hit_rise;
  logic [2:0]       hit_fall;
  logic [2:0]       hit_flag;
  logic [2:0]       port_on;
  logic             fuse_block;
  logic             running;
  logic             summary;
  logic             wr;
  port_byte_t       wbyte;

  // bundle the bus request
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                 adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  // three-stage synchroniser for pins and fuse straps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {low_voltage_program_fuse_i, reset_pin_enable_fuse_i,
               pins_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // level moves only when stages two and three agree
  assign lvl_nxt = (~(s2_r ^ s3_r) & s3_r)
                 | ((s2_r ^ s3_r) & lvl_r);

  // priming stops a high pin at reset release looking like an edge
  always_comb begin
    state_nxt = state_r;
    prime_nxt = prime_r;
    case (state_r)
      ST_PRIME: begin
        prime_nxt = 2'(prime_r + 2'h1);
        if (prime_r == PRIME_CYCLES) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        prime_nxt = prime_r;
      end
      default: begin
        state_nxt = ST_PRIME;
        prime_nxt = 2'h0;
      end
    endcase
  end

  // priming state and settled pin levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_PRIME;
      prime_r <= 2'h0;
      lvl_r   <= '0;
    end else begin
      state_r <= state_nxt;
      prime_r <= prime_nxt;
      lvl_r   <= lvl_nxt;
    end
  end

  // detectors stay blind until priming ends
  assign running = (state_r == ST_RUN);

  // ports present for this package size
  assign port_on[0] = 1'b1;
  assign port_on[1] = (PACKAGE_PINS >= 20);
  assign port_on[2] = (PACKAGE_PINS >= 14);

  // either fuse takes the reset pin away from the port
  assign fuse_block = lvl_r[FUSE_RST_POS] | lvl_r[FUSE_LVP_POS];

  // pins that may detect: present ports, minus a fused reset pin
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      avail[p*PORT_W +: PORT_W] = port_on[p] ? PORT_PINS[p] : 8'h00;
    end
    avail[RESET_PIN_BIT] = PORT_PINS[0][RESET_PIN_BIT]
                         & ~fuse_block;
  end

  // separate per-pin rising and falling detectors
  assign rise_ev = {PINS_W{running}} & lvl_nxt[PINS_W-1:0]
                 & ~lvl_r[PINS_W-1:0] & rise_r & avail;
  assign fall_ev = {PINS_W{running}} & ~lvl_nxt[PINS_W-1:0]
                 & lvl_r[PINS_W-1:0] & fall_r & avail;
  assign edge_ev = rise_ev | fall_ev;

  // address decode
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      hit_rise[p] = idx_hit(req.adr, RISE_IDX[p]);
      hit_fall[p] = idx_hit(req.adr, FALL_IDX[p]);
      hit_flag[p] = idx_hit(req.adr, FLAG_IDX[p]);
      port_ev[p]  = |byte_of(edge_ev, p);
    end
  end

  // writes land on the edge that samples ack
  assign wr    = req.cyc & req.stb & req.we & ack_r & req.sel[0];
  assign wbyte = req.dat[7:0];

  // enable and flag next values, per port byte
  always_comb begin
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    flag_nxt = flag_r;
    for (int p = 0; p < NPORTS; p++) begin
      if (wr && hit_rise[p]) begin
        rise_nxt[p*PORT_W +: PORT_W] = wbyte & PORT_PINS[p];
      end
      if (wr && hit_fall[p]) begin
        fall_nxt[p*PORT_W +: PORT_W] = wbyte & PORT_PINS[p];
      end
      if (wr && hit_flag[p]) begin
        flag_nxt[p*PORT_W +: PORT_W] = wbyte & PORT_PINS[p];
      end
    end
    // an edge during a clearing write still leaves its flag set
    flag_nxt = (flag_nxt & avail) | edge_ev;
  end

  // event status: set wins over write-one-to-clear
  assign evt_stat_nxt = (evt_stat_r
                        & ~({3{wr && idx_hit(req.adr, EVT_STAT_IDX)}}
                            & wbyte[2:0])) | port_ev;

  // enable and flag registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rise_r <= '0;
      fall_r <= '0;
      flag_r <= '0;
    end else begin
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      flag_r <= flag_nxt;
    end
  end

  // control, event status and mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_en_r <= 1'b0;
      evt_stat_r  <= EVT_RST;
      evt_mask_r  <= EVT_RST;
    end else begin
      if (wr && idx_hit(req.adr, CTRL_IDX)) begin
        master_en_r <= wbyte[MASTER_EN_BIT];
      end
      if (wr && idx_hit(req.adr, EVT_MASK_IDX)) begin
        evt_mask_r <= wbyte[2:0];
      end
      evt_stat_r <= evt_stat_nxt;
    end
  end

  // summary is a pure or, so it has no state to write
  assign summary = |flag_r;

  // read mux, unmapped words read as zero
  always_comb begin
    rdat_nxt = 32'h0000_0000;
    for (int p = 0; p < NPORTS; p++) begin
      if (hit_rise[p]) begin
        rdat_nxt[7:0] = byte_of(rise_r, p);
      end
      if (hit_fall[p]) begin
        rdat_nxt[7:0] = byte_of(fall_r, p);
      end
      if (hit_flag[p]) begin
        rdat_nxt[7:0] = byte_of(flag_r, p);
      end
    end
    if (idx_hit(req.adr, CTRL_IDX)) begin
      rdat_nxt[MASTER_EN_BIT] = master_en_r;
    end
    if (idx_hit(req.adr, SUMMARY_IDX)) begin
      rdat_nxt[SUMMARY_BIT] = summary;
    end
    if (idx_hit(req.adr, EVT_STAT_IDX)) begin
      rdat_nxt[2:0] = evt_stat_r;
    end
    if (idx_hit(req.adr, EVT_MASK_IDX)) begin
      rdat_nxt[2:0] = evt_mask_r;
    end
  end

  // one wait state: ack one cycle after the request, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r  <= req.cyc & req.stb & ~ack_r;
      rdat_r <= rdat_nxt;
    end
  end

  // bus outputs straight from flops
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // processor request gated by the master enable
  assign change_irq_o = master_en_r & summary;

  // flags are already registered when wake rises
  assign wake_o = sleep_i & master_en_r & summary;

  // system interrupt from masked sticky events
  assign irq_o = |(evt_stat_r & evt_mask_r);

endmodule // pin_change_interrupt

// file: tb/ext_pins.sv
// off-chip drivers on the three ports
module ext_pins
  import pin_change_pkg::*;
(
  input  wire pin_change_pkg::port_trio_t level_i,
  output pin_change_pkg::port_trio_t      pins_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // skew keeps pin moves clear of the sampling edge
  // continuous, so the level at time zero reaches the pins as well
  assign #7 pins_o = level_i;
endmodule // ext_pins

// file: tb/pin_change_interrupt_assertions.sv
// port assertions for the pin change interrupt block
module pin_change_interrupt_assertions
  import pin_change_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic       wb_ack_o,
  input wire port_trio_t pins_i,
  input wire logic       reset_pin_enable_fuse_i,
  input wire logic       low_voltage_program_fuse_i,
  input wire logic       sleep_i,
  input wire logic       change_irq_o,
  input wire logic       wake_o,
  input wire logic       irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       wr_s;
  logic       fuse_s;
  logic [2:0] quiet_r;
  port_trio_t pins_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign wr_s = wb_ack_o && wb_we_i;
  assign fuse_s = reset_pin_enable_fuse_i || low_voltage_program_fuse_i;
  // edges since the pins last moved; saturates, only small counts matter
  always_ff @(posedge clk_i) begin
    pins_r <= pins_i;
    if (rst_i || pins_i != pins_r) quiet_r <= 3'h0;
    else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // pins settled and no write landed on the last edge
  sequence s_calm;
    quiet_r >= 3'h6 && !$past(wr_s);
  endsequence
  property p_ack_next; s_req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_cause; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  property p_wake; wake_o == (sleep_i && change_irq_o); endproperty
  property p_chg_hold;
    change_irq_o && !wr_s && !fuse_s |=> change_irq_o;
  endproperty
  property p_chg_cause; s_calm |-> !$rose(change_irq_o); endproperty
  property p_evt_cause; s_calm |-> !$rose(irq_o); endproperty
  property p_evt_hold; $fell(irq_o) |-> $past(wr_s); endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_wake: assert property (p_wake)
    else $error("wake mismatch");
  a_chg_hold: assert property (p_chg_hold)
    else $error("request dropped without write");
  a_chg_cause: assert property (p_chg_cause)
    else $error("request rose with quiet pins");
  a_evt_cause: assert property (p_evt_cause)
    else $error("event irq rose with quiet pins");
  a_evt_hold: assert property (p_evt_hold)
    else $error("event irq dropped without write");
endmodule // pin_change_interrupt_assertions
bind pin_change_interrupt pin_change_interrupt_assertions chk_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .pins_i(pins_i), .reset_pin_enable_fuse_i(reset_pin_enable_fuse_i),
  .low_voltage_program_fuse_i(low_voltage_program_fuse_i),
  .sleep_i(sleep_i), .change_irq_o(change_irq_o),
  .wake_o(wake_o), .irq_o(irq_o));

// file: tb/testbench.sv
// self-checking bench for the pin change interrupt block
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pin_change_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, chg, wake, irq, slp, me;
  logic [15:0] adr;
  logic [31:0] dat, q, v;
  logic [1:0]  fz;
  port_trio_t  lvl, pins;
  int          n_errors, checked, p, b, m;
  ext_pins ext_pins_i (.level_i(lvl), .pins_o(pins));
  pin_change_interrupt pin_change_interrupt_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(q),
    .wb_ack_o(ack), .pins_i(pins), .reset_pin_enable_fuse_i(fz[0]),
    .low_voltage_program_fuse_i(fz[1]), .sleep_i(slp),
    .change_irq_o(chg), .wake_o(wake), .irq_o(irq));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // classic cycle, request held until ack is sampled
  task automatic bus(input logic w, input logic [13:0] ix,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    logic to;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'h0};
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    to = (ack !== 1'b1);
    r = q;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (to) begin
      n_errors++;
      $display("[ERR] %0t bus ack %h exp %h", $time, ack, 1'b1);
      stop_test();
    end
  endtask
  task automatic wr(input logic [13:0] ix, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, ix, d, r);
  endtask
  task automatic rd(input logic [13:0] ix, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, ix, 32'h0, r);
    chk(r, e);
  endtask
  // enables on one pin only, the rest quiet
  task automatic arm(input int pp, input int bb, input int r, input int f);
    for (int k = 0; k < 3; k++) begin
      wr(RISE_IDX[k], (k == pp && r != 0) ? 32'h1 << bb : 32'h0);
      wr(FALL_IDX[k], (k == pp && f != 0) ? 32'h1 << bb : 32'h0);
    end
  endtask
  // toggle pin b of port p, then clear every flag of port p with a zero write
  task automatic flip(input int r, input int f);
    logic e;
    lvl[p*8+b] <= ~lvl[p*8+b];
    repeat (6) @(posedge clk_i);
    e = lvl[p*8+b] ? r[0] : f[0];
    rd(FLAG_IDX[p], 32'(e) << b);
    rd(SUMMARY_IDX, 32'(e));
    chk(32'(chg), 32'(e & me));
    chk(32'(wake), 32'(e & me & slp));
    wr(FLAG_IDX[p], 32'h0);
    rd(SUMMARY_IDX, 32'h0);
  endtask
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, slp, me, fz, adr, dat, lvl} = '0;
    n_errors = 0;
    checked = 0;
    void'($urandom(1784));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (p = 0; p < 3; p++) begin
      rd(FLAG_IDX[p], 32'(REG_RST));
      rd(RISE_IDX[p], 32'(REG_RST));
      v = $urandom;
      wr(FALL_IDX[p], v);
      rd(FALL_IDX[p], 32'(v[7:0] & PORT_PINS[p]));
    end
    rd(14'h0010, 32'h0);
    wr(SUMMARY_IDX, 32'h1);
    rd(SUMMARY_IDX, 32'h0);
    $display("regs done");
    // random pins; first four passes walk every enable pair
    for (int i = 0; i < 24; i++) begin
      p = $urandom_range(2);
      b = $urandom_range(7);
      b = PORT_PINS[p][b] ? b : b ^ 4;
      m = (i < 4) ? i : $urandom_range(3);
      me = 1'($urandom_range(1));
      slp <= 1'($urandom_range(1));
      wr(CTRL_IDX, 32'(me));
      arm(p, b, m % 2, m / 2);
      flip(m % 2, m / 2);
      flip(m % 2, m / 2);
    end
    $display("edges done");
    p = 0;
    b = RESET_PIN_BIT;
    fz <= 2'($urandom_range(3, 1));
    arm(0, b, 1, 1);
    flip(0, 0);
    arm(0, b, 0, 0);
    fz <= 2'h0;
    $display("fuses done");
    // per-port event status under its mask
    wr(EVT_MASK_IDX, 32'h7);
    wr(EVT_STAT_IDX, 32'h7);
    chk(32'(irq), 32'h0);
    p = 1;
    b = 5;
    arm(1, 5, 1, 1);
    flip(1, 1);
    rd(EVT_STAT_IDX, 32'h2);
    chk(32'(irq), 32'h1);
    wr(EVT_MASK_IDX, 32'h5);
    chk(32'(irq), 32'h0);
    wr(EVT_STAT_IDX, 32'h2);
    wr(EVT_MASK_IDX, 32'h7);
    chk(32'(irq), 32'h0);
    // clearing write lands on the very edge that detects the change
    lvl[p*8+b] <= ~lvl[p*8+b];
    repeat (2) @(posedge clk_i);
    wr(FLAG_IDX[1], 32'h0);
    rd(FLAG_IDX[1], 32'h20);
    wr(FLAG_IDX[1], 32'h0);
    rd(SUMMARY_IDX, 32'h0);
    $display("events done");
    stop_test();
  end
endmodule // testbench
